// *** tb/dacbpc_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module dacbpc_chk (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        DAC_ENABLE,
    input wire logic        REF_SEL_B
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    wire take = HSEL && HTRANS[1] && HREADY;
    sequence rd_s; take && !HWRITE; endsequence
    sequence rp_s; rd_s ##0 HADDR == 32'h8c; endsequence
    sequence wc_s; take && HWRITE && HADDR == 32'h84 ##1 1'b1; endsequence
    chk_resp_okay: assert property (HRESP == 1'b0) else $error("bad response");
    chk_read_wait: assert property (rd_s |=> !HREADYOUT ##1 HREADYOUT) else $error("read wait");
    chk_write_zero: assert property (take && HWRITE |=> HREADYOUT) else $error("write wait");
    chk_ready_once: assert property (!HREADYOUT |=> HREADYOUT) else $error("long wait");
    chk_rdata_hold: assert property ($changed(HRDATA) |-> $rose(HREADYOUT))
        else $error("read data moved");
    chk_ptr_bound: assert property (rp_s ##2 1'b1 |->
        HRDATA[7:4] <= HRDATA[3:0] && HRDATA[31:8] == 24'h0) else $error("pointer above limit");
    chk_ref_follow: assert property (wc_s |-> ##2 REF_SEL_B == $past(HWDATA[1], 2))
        else $error("reference select lost");
    chk_en_follow: assert property (wc_s |-> ##2 DAC_ENABLE == $past(HWDATA[0], 2))
        else $error("enable lost");
endmodule
bind dacbpc_top dacbpc_chk u_dacbpc_chk (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DAC_ENABLE(DAC_ENABLE),
    .REF_SEL_B(REF_SEL_B));
`default_nettype wire

// *** tb/dacbpc_conv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dacbpc_conv_model #(
    parameter int REF_A = 1,
    parameter int REF_B = 2
) (
    input  wire dacbpc_pkg::dacbpc_word_t code,
    input  wire logic                     en,
    input  wire logic                     sel_b,
    output logic [31:0]                   level
);
    import dacbpc_pkg::*;
    assign level = en ? 32'(code) * 32'(sel_b ? REF_B : REF_A) : 32'h0;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dacbpc_pkg::*;
    logic         clk, rstn, hsel, hwrite, trig, smp, lo_q, hrdy, hresp, den, refb;
    logic [1:0]   htrans;
    logic [31:0]  haddr, hwdata, hrdata, lvl, rnd;
    dacbpc_word_t ddata;
    int           err_total, cmp_count;
    logic [31:0]  rq[$], dq[$];
    logic [11:0]  w[16];
    logic [31:0]  ra[4] = '{32'h0, 32'h84, 32'h88, 32'h8c};
    logic [3:0]   sq[4][4] = '{'{4'h1, 4'h2, 4'h0, 4'h1}, '{4'h1, 4'h2, 4'h1, 4'h0},
                               '{4'h1, 4'h2, 4'h2, 4'h2}, '{4'h0, 4'h0, 4'h0, 4'h0}};
    dacbpc_top u_dacbpc_top (.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .BUF_TRIGGER(trig),
        .DAC_DATA(ddata), .DAC_ENABLE(den), .REF_SEL_B(refb));
    dacbpc_conv_model u_dacbpc_conv_model (.code(ddata), .en(den), .sel_b(refb), .level(lvl));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // wait states come from the slave; hold until ready sampled high
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        @(posedge clk iff hrdy);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk iff hrdy);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // output settles one edge after state change; two give margin
    task automatic dac(input logic [31:0] e);
        repeat (2) @(posedge clk);
        dq.push_back(e);
        smp <= 1'b1;
        @(posedge clk);
        smp <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (hrdy === 1'b1 && lo_q && rq.size() > 0) begin
            check(hrdata, rq.pop_front());
        end
        if (smp && dq.size() > 0) begin
            check(lvl, dq.pop_front());
        end
        lo_q <= (hrdy === 1'b0);
    end
    initial begin
        {rstn, hsel, hwrite, trig, smp, htrans, haddr, hwdata} = '0;
        err_total = 0;
        cmp_count = 0;
        rnd = 32'h1991;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd(ra[i], 32'h0);
        end
        for (int i = 0; i < 16; i++) begin
            rnd = xs(rnd);
            w[i] = rnd[11:0];
            bus(1'b1, 32'(i * 4), rnd);
        end
        bus(1'b1, 32'h3fc, rnd);
        for (int i = 0; i < 16; i++) begin
            rd(32'(i * 4), {20'h0, w[i]});
        end
        rd(32'h3fc, 32'h0);
        $display("test words done");
        bus(1'b1, 32'h8c, 32'h23);
        bus(1'b1, 32'h84, 32'h5);
        rd(32'h8c, 32'h23);
        dac(32'(w[0]));
        bus(1'b1, 32'h8c, 32'hf3);
        rd(32'h8c, 32'h33);
        $display("test first word done");
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 32'h8c, 32'h02);
            bus(1'b1, 32'h88, 32'(m * 2 + 1));
            for (int k = 0; k < 4; k++) begin
                bus(1'b1, 32'h84, 32'(5 + (m % 2) * 2));
                rd(32'h8c, {24'h0, sq[m][k], 4'h2});
                dac(32'(w[sq[m][k]]) * 32'(m % 2 + 1));
            end
        end
        rd(32'h88, 32'h7);
        rd(32'h84, 32'h3);
        $display("test modes done");
        bus(1'b1, 32'h88, 32'h1);
        bus(1'b1, 32'h8c, 32'h05);
        trig <= 1'b1;
        repeat (3) @(posedge clk);
        trig <= 1'b0;
        repeat (6) @(posedge clk);
        rd(32'h8c, 32'h15);
        bus(1'b1, 32'h84, 32'h0);
        dac(32'h0);
        $display("test pin and disable done");
        repeat (4) @(posedge clk);
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire

// *** verilog/dacbpc_consts.svh ***
`ifndef DACBPC_CONSTS_SVH
`define DACBPC_CONSTS_SVH

// register indices; byte address is four times the index
`define DACBPC_IDX_CONTROL      8'h21
`define DACBPC_IDX_CONFIG       8'h22
`define DACBPC_IDX_POINTER      8'h23
`define DACBPC_IDX_WORD_LAST    8'h0f

// control register fields
`define DACBPC_CTL_ENABLE_BIT   0
`define DACBPC_CTL_REFSEL_BIT   1
`define DACBPC_CTL_SWTRIG_BIT   2

// config register fields
`define DACBPC_CFG_PTREN_BIT    0
`define DACBPC_CFG_MODE_LSB     1
`define DACBPC_CFG_MODE_MSB     2

// pointer register fields
`define DACBPC_PTR_RP_LSB       4
`define DACBPC_PTR_RP_MSB       7
`define DACBPC_PTR_UP_LSB       0
`define DACBPC_PTR_UP_MSB       3

// reset values
`define DACBPC_RST_CONTROL      8'h00
`define DACBPC_RST_CONFIG       8'h00
`define DACBPC_RST_PTR          4'h0
`define DACBPC_RST_LIMIT        4'h0
`define DACBPC_RST_WORD         12'h000

`define DACBPC_WORD_BITS        12
`define DACBPC_DEPTH            16

`endif

// *** verilog/dacbpc_pkg.sv ***
package dacbpc_pkg;

    typedef enum logic [1:0] {
        DACBPC_MODE_NORMAL   = 2'b00,
        DACBPC_MODE_SWING    = 2'b01,
        DACBPC_MODE_ONESCAN  = 2'b10,
        DACBPC_MODE_RESERVED = 2'b11
    } dacbpc_mode_t;

    typedef enum logic [1:0] {
        DACBPC_BUS_IDLE  = 2'b00,
        DACBPC_BUS_WRITE = 2'b01,
        DACBPC_BUS_READ  = 2'b10
    } dacbpc_bus_t;

    typedef logic [3:0]  dacbpc_ptr_t;
    typedef logic [11:0] dacbpc_word_t;

endpackage

// *** verilog/dacbpc_ptr_step.sv ***
`timescale 1ns/1ps
`default_nettype none

module dacbpc_ptr_step (
    input  wire dacbpc_pkg::dacbpc_mode_t mode,
    input  wire dacbpc_pkg::dacbpc_ptr_t  ptr,
    input  wire dacbpc_pkg::dacbpc_ptr_t  limit,
    input  wire logic                     dir_down,
    output dacbpc_pkg::dacbpc_ptr_t       ptr_nxt,
    output logic                          dir_down_nxt
);
    import dacbpc_pkg::*;

    wire logic at_top  = (ptr >= limit);
    wire logic at_zero = (ptr == 4'h0);
    wire dacbpc_ptr_t ptr_inc = ptr + 4'h1;
    wire dacbpc_ptr_t ptr_dec = ptr - 4'h1;

    always_comb begin
        ptr_nxt      = ptr;
        dir_down_nxt = dir_down;
        case (mode)
            DACBPC_MODE_NORMAL: begin
                ptr_nxt = at_top ? 4'h0 : ptr_inc;
            end
            DACBPC_MODE_SWING: begin
                if (limit == 4'h0) begin
                    ptr_nxt      = 4'h0;
                    dir_down_nxt = 1'b0;
                end else if (!dir_down) begin
                    ptr_nxt      = at_top ? ptr_dec : ptr_inc;
                    dir_down_nxt = at_top;
                end else begin
                    ptr_nxt      = at_zero ? ptr_inc : ptr_dec;
                    dir_down_nxt = !at_zero;
                end
            end
            DACBPC_MODE_ONESCAN: begin
                ptr_nxt = at_top ? limit : ptr_inc;
            end
            // reserved code holds the pointer
            default: begin
                ptr_nxt = ptr;
            end
        endcase
    end
endmodule

`default_nettype wire

// *** verilog/dacbpc_top.sv ***
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dacbpc_consts.svh"

module dacbpc_top (
    input  wire logic                CLK,
    input  wire logic                RSTN,
    input  wire logic                HSEL,
    input  wire logic [31:0]         HADDR,
    input  wire logic [1:0]          HTRANS,
    input  wire logic                HWRITE,
    input  wire logic [2:0]          HSIZE,
    input  wire logic [31:0]         HWDATA,
    input  wire logic                HREADY,
    output logic [31:0]              HRDATA,
    output logic                     HREADYOUT,
    output logic                     HRESP,
    input  wire logic                BUF_TRIGGER,
    output dacbpc_pkg::dacbpc_word_t DAC_DATA,
    output logic                     DAC_ENABLE,
    output logic                     REF_SEL_B
);
    import dacbpc_pkg::*;

    // word index from a byte address; 0xff marks misaligned or out of range
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = (addr[1:0] != 2'b00 || addr[31:10] != 22'h0) ? 8'hff : addr[9:2];
    endfunction

    function automatic logic is_word(input logic [7:0] idx);
        is_word = (idx <= `DACBPC_IDX_WORD_LAST);
    endfunction

    // bus slave state
    dacbpc_bus_t  bus_r;
    dacbpc_bus_t  bus_nxt;
    logic [7:0]   idx_r;
    logic [31:0]  hrdata_r;
    logic         hready_r;

    // software visible state
    logic [7:0]   control_r;
    logic [7:0]   config_r;
    dacbpc_ptr_t  ptr_r;
    dacbpc_ptr_t  limit_r;
    logic         dir_down_r;
    dacbpc_word_t words [0:`DACBPC_DEPTH-1];

    // converter facing outputs
    dacbpc_word_t dac_data_r;
    logic         dac_en_r;
    logic         ref_b_r;

    // trigger pin synchroniser
    logic         trig_s1_r;
    logic         trig_s2_r;
    logic         trig_s3_r;

    // address phase decode
    wire logic       addr_ok   = HSEL && HTRANS[1] && HREADY;
    wire logic [7:0] addr_idx  = reg_index(HADDR);

    always_comb begin
        bus_nxt = DACBPC_BUS_IDLE;
        if (addr_ok) begin
            bus_nxt = HWRITE ? DACBPC_BUS_WRITE : DACBPC_BUS_READ;
        end
    end

    // data phase decode
    wire logic wr_phase  = (bus_r == DACBPC_BUS_WRITE);
    wire logic rd_phase  = (bus_r == DACBPC_BUS_READ);
    wire logic wr_word   = wr_phase && is_word(idx_r);
    wire logic wr_ctl    = wr_phase && (idx_r == `DACBPC_IDX_CONTROL);
    wire logic wr_cfg    = wr_phase && (idx_r == `DACBPC_IDX_CONFIG);
    wire logic wr_ptr    = wr_phase && (idx_r == `DACBPC_IDX_POINTER);

    // field views
    wire logic         ptr_en    = config_r[`DACBPC_CFG_PTREN_BIT];
    wire dacbpc_mode_t mode      =
        dacbpc_mode_t'(config_r[`DACBPC_CFG_MODE_MSB:`DACBPC_CFG_MODE_LSB]);
    wire logic         conv_en   = control_r[`DACBPC_CTL_ENABLE_BIT];

    // a software trigger is a write of one to the self clearing trigger bit
    wire logic sw_trig   = wr_ctl && HWDATA[`DACBPC_CTL_SWTRIG_BIT];
    wire logic hw_trig   = trig_s2_r && !trig_s3_r;
    wire logic step      = (sw_trig || hw_trig) && ptr_en;

    // software pointer write is clamped so the pointer stays within limit
    wire dacbpc_ptr_t wr_rp  = HWDATA[`DACBPC_PTR_RP_MSB:`DACBPC_PTR_RP_LSB];
    wire dacbpc_ptr_t wr_up  = HWDATA[`DACBPC_PTR_UP_MSB:`DACBPC_PTR_UP_LSB];
    wire dacbpc_ptr_t wr_rp_clamped = (wr_rp > wr_up) ? wr_up : wr_rp;

    dacbpc_ptr_t step_ptr;
    logic        step_dir;

    dacbpc_ptr_step u_step (
        .mode         (mode),
        .ptr          (ptr_r),
        .limit        (limit_r),
        .dir_down     (dir_down_r),
        .ptr_nxt      (step_ptr),
        .dir_down_nxt (step_dir)
    );

    wire dacbpc_ptr_t  sel_idx   = ptr_en ? ptr_r : 4'h0;
    wire dacbpc_word_t sel_word  = words[sel_idx];

    // read mux; word index comes from the latched data phase address
    wire dacbpc_ptr_t  rd_widx   = idx_r[3:0];
    wire logic [31:0]  rd_value  =
        is_word(idx_r)                     ? {20'h0, words[rd_widx]} :
        (idx_r == `DACBPC_IDX_CONTROL)     ? {24'h0, control_r} :
        (idx_r == `DACBPC_IDX_CONFIG)      ? {24'h0, config_r} :
        (idx_r == `DACBPC_IDX_POINTER)     ? {24'h0, ptr_r, limit_r} :
        32'h0;

    // bus handshake; reads take one wait state so the read data is a flop
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            bus_r    <= DACBPC_BUS_IDLE;
            idx_r    <= 8'hff;
            hready_r <= 1'b1;
            hrdata_r <= 32'h0;
        end else if (hready_r) begin
            bus_r    <= bus_nxt;
            idx_r    <= addr_ok ? addr_idx : 8'hff;
            // wait must show in the first data phase cycle, or the master ends early
            hready_r <= !(addr_ok && !HWRITE);
        end else begin
            bus_r    <= DACBPC_BUS_IDLE;
            hready_r <= 1'b1;
            if (rd_phase) begin
                hrdata_r <= rd_value;
            end
        end
    end

    // control and config; the trigger bit never stores
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            control_r <= `DACBPC_RST_CONTROL;
            config_r  <= `DACBPC_RST_CONFIG;
        end else begin
            if (wr_ctl) begin
                control_r <= {6'h0, HWDATA[`DACBPC_CTL_REFSEL_BIT],
                              HWDATA[`DACBPC_CTL_ENABLE_BIT]};
            end
            if (wr_cfg) begin
                config_r <= {5'h0, HWDATA[`DACBPC_CFG_MODE_MSB:`DACBPC_CFG_MODE_LSB],
                             HWDATA[`DACBPC_CFG_PTREN_BIT]};
            end
        end
    end

    // data buffer; word zero is the first data word
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            for (int i = 0; i < `DACBPC_DEPTH; i++) begin
                words[i] <= `DACBPC_RST_WORD;
            end
        end else if (wr_word) begin
            words[rd_widx] <= HWDATA[11:0];
        end
    end

    // pointer and limit; a software write wins over a same cycle step
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ptr_r      <= `DACBPC_RST_PTR;
            limit_r    <= `DACBPC_RST_LIMIT;
            dir_down_r <= 1'b0;
        end else if (wr_ptr) begin
            ptr_r      <= wr_rp_clamped;
            limit_r    <= wr_up;
            dir_down_r <= 1'b0;
        end else if (step) begin
            ptr_r      <= step_ptr;
            dir_down_r <= step_dir;
        end
    end

    // trigger pin: two flops, then an edge detector on the second
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
        end else begin
            trig_s1_r <= BUF_TRIGGER;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
        end
    end

    // converter outputs; disabled converter sees zero data
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            dac_data_r <= `DACBPC_RST_WORD;
            dac_en_r   <= 1'b0;
            ref_b_r    <= 1'b0;
        end else begin
            dac_data_r <= conv_en ? sel_word : `DACBPC_RST_WORD;
            dac_en_r   <= conv_en;
            ref_b_r    <= control_r[`DACBPC_CTL_REFSEL_BIT];
        end
    end

    assign HRDATA     = hrdata_r;
    assign HREADYOUT  = hready_r;
    assign HRESP      = 1'b0;
    assign DAC_DATA   = dac_data_r;
    assign DAC_ENABLE = dac_en_r;
    assign REF_SEL_B  = ref_b_r;

endmodule

`default_nettype wire
